// *** core/ltp_pkg.sv ***
/*
 * ltp_pkg: constants, register indices, field positions and carrier
 * types for the link-training page register bank.
 * Assumes one clock domain; the byte address of a register is its
 * printed offset (index) times four, and the receive bank sits at
 * a fixed index base above the transmit bank.
 */
package ltp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PAGE_W = 32;
    // printed offsets, kept as indices
    localparam logic [3:0] IDX_MAIN = 4'h0;
    localparam logic [3:0] IDX_PAGE0 = 4'h4;
    localparam logic [3:0] IDX_PAGE3 = 4'h7;
    localparam logic [3:0] IDX_RX_BASE = 4'h8;
    localparam int BYTE_SHIFT = 2;
    // main control field positions
    localparam int BIT_DP_RST = 7;
    localparam int BIT_ENABLE = 6;
    localparam int BIT_IRQ_EN = 5;
    localparam int BIT_BYPASS = 4;
    localparam int BIT_LOCK = 3;
    localparam int BIT_RESTART = 1;
    localparam int BIT_READY = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [PAGE_W-1:0] RESET_PAGE = 32'h0000_0000;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        LTP_SEL_NONE = 4'h0,
        LTP_SEL_TX_MAIN = 4'h1,
        LTP_SEL_TX_PAGE = 4'h3,
        LTP_SEL_RX_MAIN = 4'h2,
        LTP_SEL_RX_PAGE = 4'h6
    } ltp_sel_type;

    typedef struct packed {
        logic [PAGE_W-1:0] page;
        logic valid;
    } ltp_page_type;

    typedef struct packed {
        logic dp_rst;
        logic enable;
        logic ready;
        logic [PAGE_W-1:0] page;
    } ltp_tx_type;

    typedef struct packed {
        logic dp_rst;
        logic enable;
        logic irq_en;
        logic ready;
        logic restart;
        logic irq;
        logic [PAGE_W-1:0] page;
    } ltp_rx_type;

    typedef struct packed {
        ltp_tx_type tx;
        ltp_rx_type rx;
        logic drive;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } ltp_state_type;
endpackage : ltp_pkg

// *** core/ltp_sync.sv ***
/*
 * ltp_sync: two-stage synchroniser for slow level inputs from pins.
 * Assumes the inputs are levels that hold for several clocks.
 */
`timescale 1ns/1ps
module ltp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import ltp_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } ltp_sync_type;

    ltp_sync_type r;
    ltp_sync_type next_r;

    always_comb begin
        next_r = r;
        if (ce_in) begin
            next_r.meta = async_in;
            next_r.held = r.meta;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.held;
endmodule : ltp_sync

// *** core/ltp_regs.sv ***
/*
 * ltp_regs: software-visible control and page registers for the
 * link-training transmit and receive dataplanes, on an APB port.
 * Assumes both dataplanes run on clk_sys_in; only the external
 * bypass indication arrives from a pin and is synchronised here.
 */
`timescale 1ns/1ps
module ltp_regs (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ltp_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [ltp_pkg::DATA_W-1:0] pwdata_in,
    output logic [ltp_pkg::DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic ext_bypass_in,
    input wire logic tx_page_taken_in,
    output logic tx_dp_rst_out,
    output logic tx_drive_out,
    output ltp_pkg::ltp_page_type tx_page_out,
    input wire logic rx_lock_in,
    input wire ltp_pkg::ltp_page_type rx_page_in,
    output logic rx_dp_rst_out,
    output logic rx_restart_out,
    output logic irq_out
);
    import ltp_pkg::*;

    ltp_state_type r;
    ltp_state_type next_r;
    logic bypass_s;
    ltp_sel_type sel;
    logic [1:0] byte_sel;
    logic access;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    ltp_sync #(
        .WIDTH(1)
    ) u_bypass_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .async_in(ext_bypass_in),
        .sync_out(bypass_s)
    );

    // maps a byte address onto a register group; used for read and write
    function automatic ltp_sel_type decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [3:0] idx;
        logic [3:0] loc;
        ltp_sel_type s;
        idx = addr[BYTE_SHIFT +: 4];
        loc = (idx >= IDX_RX_BASE) ? idx - IDX_RX_BASE : idx;
        s = LTP_SEL_NONE;
        if (addr[BYTE_SHIFT-1:0] == 2'h0 && addr[ADDR_W-1:BYTE_SHIFT+4]
            == '0) begin
            if (loc == IDX_MAIN) begin
                s = (idx >= IDX_RX_BASE) ? LTP_SEL_RX_MAIN : LTP_SEL_TX_MAIN;
            end else if (loc >= IDX_PAGE0 && loc <= IDX_PAGE3) begin
                s = (idx >= IDX_RX_BASE) ? LTP_SEL_RX_PAGE : LTP_SEL_TX_PAGE;
            end
        end
        return s;
    endfunction : decode

    assign sel = decode(paddr_in);
    assign byte_sel = paddr_in[BYTE_SHIFT +: 2];
    assign access = psel_in && penable_in && !r.pready;
    assign wbyte = pwdata_in[7:0];

    // read view of the addressed register
    always_comb begin
        rd_byte = 8'h00;
        unique case (sel)
            LTP_SEL_TX_MAIN: begin
                rd_byte[BIT_DP_RST] = r.tx.dp_rst;
                rd_byte[BIT_ENABLE] = r.tx.enable;
                rd_byte[BIT_BYPASS] = bypass_s;
                rd_byte[BIT_READY] = r.tx.ready;
            end
            LTP_SEL_TX_PAGE: begin
                rd_byte = r.tx.page[8*byte_sel +: 8];
            end
            LTP_SEL_RX_MAIN: begin
                rd_byte[BIT_DP_RST] = r.rx.dp_rst;
                rd_byte[BIT_ENABLE] = r.rx.enable;
                rd_byte[BIT_IRQ_EN] = r.rx.irq_en;
                rd_byte[BIT_LOCK] = rx_lock_in;
                rd_byte[BIT_RESTART] = 1'b0;
                rd_byte[BIT_READY] = r.rx.ready;
            end
            LTP_SEL_RX_PAGE: begin
                rd_byte = r.rx.page[8*byte_sel +: 8];
            end
            LTP_SEL_NONE: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_comb begin
        next_r = r;
        if (ce_in) begin
            next_r.pready = access;
            next_r.pslverr = access && (sel == LTP_SEL_NONE);
            next_r.rx.restart = 1'b0;
            if (access && !pwrite_in) begin
                next_r.prdata = {{(DATA_W-8){1'b0}}, rd_byte};
            end
            // device clears tx ready once the page is copied
            if (tx_page_taken_in && !r.tx.dp_rst) begin
                next_r.tx.ready = 1'b0;
            end
            // capture only while no page is pending
            if (rx_page_in.valid && !r.rx.ready && !r.rx.dp_rst) begin
                next_r.rx.page = rx_page_in.page;
                next_r.rx.ready = 1'b1;
            end
            if (access && pwrite_in) begin
                unique case (sel)
                    LTP_SEL_TX_MAIN: begin
                        next_r.tx.dp_rst = wbyte[BIT_DP_RST];
                        next_r.tx.enable = wbyte[BIT_ENABLE];
                        // software set wins over a same-cycle copy
                        if (wbyte[BIT_READY]) begin
                            next_r.tx.ready = 1'b1;
                        end
                    end
                    LTP_SEL_TX_PAGE: begin
                        next_r.tx.page[8*byte_sel +: 8] = wbyte;
                    end
                    LTP_SEL_RX_MAIN: begin
                        next_r.rx.dp_rst = wbyte[BIT_DP_RST];
                        // stored only for read-back, steers nothing
                        next_r.rx.enable = wbyte[BIT_ENABLE];
                        next_r.rx.irq_en = wbyte[BIT_IRQ_EN];
                        next_r.rx.restart = wbyte[BIT_RESTART];
                        // a capture in the same cycle is kept
                        if (wbyte[BIT_READY] && !(rx_page_in.valid
                            && !r.rx.ready && !r.rx.dp_rst)) begin
                            next_r.rx.ready = 1'b0;
                        end
                    end
                    LTP_SEL_RX_PAGE: begin
                        // read-only; a same-cycle capture must survive
                    end
                    LTP_SEL_NONE: begin
                        // unmapped: answered with an error, nothing stored
                    end
                endcase
            end
            // interrupt follows the committed flag and enable
            next_r.rx.irq = next_r.rx.irq_en && next_r.rx.ready;
            next_r.drive = next_r.tx.enable && !bypass_s
                && !next_r.tx.dp_rst;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            r.tx.dp_rst <= RESET_BYTE[BIT_DP_RST];
            r.tx.enable <= RESET_BYTE[BIT_ENABLE];
            r.tx.ready <= RESET_BYTE[BIT_READY];
            r.tx.page <= RESET_PAGE;
            r.rx.dp_rst <= RESET_BYTE[BIT_DP_RST];
            r.rx.enable <= RESET_BYTE[BIT_ENABLE];
            r.rx.irq_en <= RESET_BYTE[BIT_IRQ_EN];
            r.rx.ready <= RESET_BYTE[BIT_READY];
            r.rx.restart <= 1'b0;
            r.rx.irq <= 1'b0;
            r.rx.page <= RESET_PAGE;
            r.drive <= 1'b0;
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            r.prdata <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata_out = r.prdata;
    assign pready_out = r.pready;
    assign pslverr_out = r.pslverr;
    assign tx_dp_rst_out = r.tx.dp_rst;
    assign rx_dp_rst_out = r.rx.dp_rst;
    assign tx_drive_out = r.drive;
    assign tx_page_out = '{page: r.tx.page, valid: r.tx.ready};
    assign rx_restart_out = r.rx.restart;
    assign irq_out = r.rx.irq;
endmodule : ltp_regs

// *** dv/ltp_regs_assertions.sv ***
/*
 * ltp_regs_assertions: port-level checks for ltp_regs.
 * Assumes one clock, synchronous active-high reset; bound below.
 */
`timescale 1ns/1ps
module ltp_regs_assertions (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic ext_bypass_in,
    input wire logic tx_page_taken_in,
    input wire logic tx_dp_rst_out,
    input wire logic tx_drive_out,
    input wire ltp_pkg::ltp_page_type tx_page_out,
    input wire logic rx_restart_out,
    input wire logic irq_out
);
    import ltp_pkg::*;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_take;
        psel_in && penable_in && !pready_out && ce_in;
    endsequence
    sequence s_ans;
        pready_out ##1 !pready_out;
    endsequence
    chk_apb_answer: assert property (s_take |=> s_ans)
        else $error("apb access not answered in one cycle");
    chk_err_pulse: assert property (pslverr_out |-> pready_out)
        else $error("slave error outside answer");
    chk_rd_upper: assert property (pready_out |-> !(|prdata_out[31:8]))
        else $error("read data upper bits not zero");
    chk_bypass_drive: assert property (
        (ext_bypass_in && ce_in)[*4] |=> !tx_drive_out)
        else $error("drive while bypass reported");
    chk_rst_drive: assert property (tx_dp_rst_out[*2] |-> !tx_drive_out)
        else $error("drive while tx dataplane in reset");
    chk_tx_clear: assert property (tx_page_out.valid && tx_page_taken_in
        && !tx_dp_rst_out && !psel_in && ce_in |=> !tx_page_out.valid)
        else $error("tx ready not cleared after copy");
    chk_tx_hold: assert property (
        tx_page_out.valid && !tx_page_taken_in |=> tx_page_out.valid)
        else $error("tx ready lost without copy");
    chk_restart_cause: assert property (
        rx_restart_out |-> $past(psel_in && pwrite_in))
        else $error("restart pulse without write");
    chk_restart_pulse: assert property (rx_restart_out |=> !rx_restart_out)
        else $error("restart longer than one cycle");
    chk_irq_hold: assert property (irq_out && !psel_in |=> irq_out)
        else $error("interrupt dropped without software");
    chk_irq_fall: assert property ($fell(irq_out) |-> $past(psel_in))
        else $error("interrupt fell without access");
endmodule : ltp_regs_assertions
bind ltp_regs ltp_regs_assertions u_ltp_regs_assertions (.clk_sys_in,
    .rst_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .prdata_out,
    .pready_out, .pslverr_out, .ext_bypass_in, .tx_page_taken_in,
    .tx_dp_rst_out, .tx_drive_out, .tx_page_out, .rx_restart_out, .irq_out);

// *** dv/tb_top.sv ***
/*
 * tb_top: directed bench for ltp_regs over its apb port.
 * Assumes the register map and one-wait-state apb timing of ltp_regs.
 */
`timescale 1ns/1ps
module tb_top;
    import ltp_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ce = 1;
    logic byp = 0, taken = 0, lock = 0, er, txr, rxr, drv, rst_p, irq, err;
    logic rdy;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    ltp_page_type txp, rxp = '0;
    int n_fail = 0, check_count = 0, cyc = 0, n_pulse = 0;
    always #2.5 clk = ~clk;
    ltp_regs u_ltp_regs (.clk_sys_in(clk), .rst_in(rst), .ce_in(ce),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
        .pslverr_out(err), .ext_bypass_in(byp), .tx_page_taken_in(taken),
        .tx_dp_rst_out(txr), .tx_drive_out(drv), .tx_page_out(txp),
        .rx_lock_in(lock), .rx_page_in(rxp), .rx_dp_rst_out(rxr),
        .rx_restart_out(rst_p), .irq_out(irq));
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge clk) begin
        cyc++;
        if (rst_p === 1'b1) n_pulse++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task cy(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cy
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cy(1);
        psel = 1;
        pwr = w;
        paddr = a;
        pwd = d;
        cy(1);
        pen = 1;
        for (int i = 0; i < 8 && rdy !== 1'b1; i++) cy(1);
        rd = prd;
        er = err;
        cy(1);
        psel = 0;
        pen = 0;
        pwd = ~pwd;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask : wr
    task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    task rx_page(input logic [31:0] p);
        rxp = '{page: p, valid: 1'b1};
        cy(1);
        rxp.valid = 0;
        cy(2);
    endtask : rx_page
    task t_tx;
        rdc("tx main rst", 8'h00, 32'h0);
        for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), 32'hA0 + i);
        for (int i = 0; i < 4; i++) begin
            rdc("tx byte", 8'h10 + 8'(4 * i), 32'hA0 + i);
        end
        wr(8'h00, 32'h01);
        chk("tx page", 32'hA3A2A1A0, txp.page);
        chk("tx valid", 32'h1, {31'h0, txp.valid});
        taken = 1;
        cy(1);
        taken = 0;
        cy(1);
        chk("tx clear", 32'h0, {31'h0, txp.valid});
        wr(8'h00, 32'h40);
        chk("drive", 32'h1, {31'h0, drv});
        byp = 1;
        cy(5);
        chk("bypass drv", 32'h0, {31'h0, drv});
        rdc("bypass bit", 8'h00, 32'h50);
        byp = 0;
        wr(8'h00, 32'hC0);
        rdc("tx rst rd", 8'h00, 32'hC0);
        chk("tx rst", 32'h2, {30'h0, txr, drv});
        apb(0, 8'h08, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
    endtask : t_tx
    task t_ce;
        wr(8'h00, 32'h01);
        ce = 0;
        taken = 1;
        cy(1);
        taken = 0;
        ce = 1;
        cy(1);
        chk("ce frozen", 32'h1, {31'h0, txp.valid});
        taken = 1;
        cy(1);
        taken = 0;
        cy(1);
        chk("ce clear", 32'h0, {31'h0, txp.valid});
        wr(8'h10, 32'h5A);
        rdc("tx new", 8'h10, 32'h5A);
    endtask : t_ce
    task t_rx;
        lock = 1;
        wr(8'h20, 32'h20);
        rx_page(32'h44332211);
        chk("irq set", 32'h1, {31'h0, irq});
        for (int i = 0; i < 4; i++) begin
            rdc("rx byte", 8'h30 + 8'(4 * i), 32'h11 * (i + 1));
        end
        rdc("rx byte0", 8'h30, 32'h11);
        rdc("rx main", 8'h20, 32'h29);
        rx_page(32'h55555555);
        wr(8'h30, 32'hFF);
        rdc("rx frozen", 8'h30, 32'h11);
        wr(8'h20, 32'h20);
        chk("w0 ready", 32'h1, {31'h0, irq});
        wr(8'h20, 32'h21);
        chk("irq clr", 32'h0, {31'h0, irq});
        rdc("ready clr", 8'h20, 32'h28);
        wr(8'h20, 32'h60);
        rx_page(32'h66666666);
        chk("rx enable", 32'h1, {31'h0, irq});
        wr(8'h20, 32'h40);
        chk("irq en off", 32'h0, {31'h0, irq});
        wr(8'h20, 32'h01);
        wr(8'h20, 32'h02);
        chk("restart", 32'h1, n_pulse);
        rdc("restart rd", 8'h20, 32'h08);
        wr(8'h20, 32'h80);
        rx_page(32'h77777777);
        rdc("rx rst", 8'h20, 32'h88);
        chk("rx rst out", 32'h1, {31'h0, rxr});
    endtask : t_rx
    initial begin
        cy(10);
        rst = 0;
        t_tx();
        t_ce();
        t_rx();
        end_of_test();
    end
endmodule : tb_top
